/* File: rtl/rbt_pkg.sv */
// Contract
// - Each capture clock rising edge loads its own port into its register.
// - Capture happens regardless of enables and selects, even while driving.
// - Source select low picks live opposite port, high picks stored data.
// - Switching between live and stored data never glitches the driven port.
// - A-to-B enable high drives B; low B-to-A enable drives A; else isolation.
// - Both enables high, A-to-B select low: B follows live A.
// - Both enables high, A-to-B select high: B shows the A-to-B register.
// - Both enables low, B-to-A select low: A follows live B.
// - Both enables low, B-to-A select high: A shows the B-to-A register.
// - Both ports driven with stored data when both selects high and enabled.
// - A driving B in real time: both captures load the A value.
// - B driving A in real time: both captures load the B value.
// - Both real-time and both enabled: ports reinforce and hold last value.
// - Data path is eight identical bit slices sharing all controls.
package rbt_pkg;

    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 12;
    localparam int LOG_DEPTH = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] CTRL_OFS  = 12'h000;
    localparam logic [ADDR_W-1:0] STORE_OFS = 12'h004;
    localparam logic [ADDR_W-1:0] LIVE_OFS  = 12'h008;
    localparam logic [ADDR_W-1:0] LOG_OFS   = 12'h00C;
    localparam logic [ADDR_W-1:0] STAT_OFS  = 12'h010;

    // Field positions inside read words
    localparam int HI_LSB        = 8;
    localparam int LOG_VALID_BIT = 31;
    localparam int STAT_OVF_BIT  = 0;
    localparam int STAT_CNT_LSB  = 8;

    // Control word, low bit first: drive enables then source selects
    typedef struct packed {
        logic b_to_a_source_select;
        logic a_to_b_source_select;
        logic ba_en_n;
        logic ab_en;
    } rbt_ctrl_type;

    localparam int           CTRL_W     = $bits(rbt_ctrl_type);
    localparam rbt_ctrl_type CTRL_RESET = 4'h2;

    // One capture log entry
    typedef struct packed {
        logic              ba_hit;
        logic              ab_hit;
        logic [DATA_W-1:0] b;
        logic [DATA_W-1:0] a;
    } rbt_log_type;

    localparam int LOG_W     = $bits(rbt_log_type);
    localparam int LOG_CNT_W = $clog2(LOG_DEPTH + 1);

    typedef enum logic {APB_IDLE, APB_ACK} rbt_apb_type;

endpackage

/* File: rtl/rbt_fifo.sv */
// Capture log queue, full and empty derived from an exact count
module rbt_fifo
    import rbt_pkg::*;
#(
    parameter int W     = LOG_W,
    parameter int DEPTH = LOG_DEPTH
) (
    input  wire logic                         pclk,      // Clock
    input  wire logic                         presetn,   // Async reset, low
    input  wire logic                         in_valid,  // Push request
    output      logic                         in_ready,  // Room for a word
    input  wire logic [W-1:0]                 in_data,   // Word pushed
    output      logic                         out_valid, // Word waiting
    input  wire logic                         out_ready, // Pop request
    output      logic [W-1:0]                 out_data,  // Head word
    output      logic [$clog2(DEPTH+1)-1:0]   count      // Words held
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [CW-1:0]           cnt;
    } rbt_fifo_st_type;

    rbt_fifo_st_type st_r;
    rbt_fifo_st_type st_nxt;
    logic            push;
    logic            pop;

    // Handshake flags come from the count only
    assign in_ready  = (st_r.cnt != CW'(DEPTH));
    assign out_valid = (st_r.cnt != '0);
    assign out_data  = st_r.mem[st_r.rp];
    assign count     = st_r.cnt;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer and count update, simultaneous push and pop keep the count
    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = (st_r.wp == PW'(DEPTH - 1)) ? '0 : st_r.wp + PW'(1);
        end
        if (pop) begin
            st_nxt.rp = (st_r.rp == PW'(DEPTH - 1)) ? '0 : st_r.rp + PW'(1);
        end
        if (push && !pop) begin
            st_nxt.cnt = st_r.cnt + CW'(1);
        end else if (pop && !push) begin
            st_nxt.cnt = st_r.cnt - CW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule // rbt_fifo

/* File: rtl/rbt_top.sv */
// Registered two-way bus transceiver with APB control
//
// The implementer's own choices: the register offsets and register access over APB.
module rbt_top
    import rbt_pkg::*;
(
    input  wire logic              pclk,                 // 25 MHz clock
    input  wire logic              presetn,              // Async reset, low
    input  wire logic              psel,                 // APB select
    input  wire logic              penable,              // APB enable
    input  wire logic              pwrite,               // APB direction
    input  wire logic [ADDR_W-1:0] paddr,                // APB byte address
    input  wire logic [31:0]       pwdata,               // APB write data
    output      logic              pready,               // APB ready
    output      logic [31:0]       prdata,               // APB read data
    output      logic              pslverr,              // APB error
    input  wire logic              a_side_capture_clock, // A capture pin
    input  wire logic              b_side_capture_clock, // B capture pin
    input  wire logic [DATA_W-1:0] a_in,                 // A port level
    output      logic [DATA_W-1:0] a_out,                // A port drive
    output      logic              a_oe,                 // A drive on
    input  wire logic [DATA_W-1:0] b_in,                 // B port level
    output      logic [DATA_W-1:0] b_out,                // B port drive
    output      logic              b_oe,                 // B drive on
    output      logic              log_ready             // Log has room
);

    // Everything that resets lives here
    typedef struct packed {
        rbt_apb_type       ph;
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        rbt_ctrl_type      ctl;
        logic              ovf;
        logic              log_ready;
        logic [DATA_W-1:0] a_m;
        logic [DATA_W-1:0] a_s;
        logic [DATA_W-1:0] b_m;
        logic [DATA_W-1:0] b_s;
        logic [1:0]        cab;
        logic [1:0]        cba;
        logic              cab_d;
        logic              cba_d;
        logic [DATA_W-1:0] hold;
        logic [DATA_W-1:0] a_out;
        logic [DATA_W-1:0] b_out;
        logic              a_oe;
        logic              b_oe;
    } rbt_state_type;

    // Capture registers, kept apart because they never reset
    typedef struct packed {
        logic [DATA_W-1:0] ab;
        logic [DATA_W-1:0] ba;
    } rbt_store_type;

    rbt_state_type     s_r;
    rbt_state_type     s_nxt;
    rbt_store_type     d_r;
    rbt_store_type     d_nxt;

    logic              ab_edge;
    logic              ba_edge;
    logic              ab_rt;
    logic              ba_rt;
    logic              hold_mode;
    logic              addr_hit;
    logic [31:0]       rd_word;
    logic [DATA_W-1:0] a_sl;
    logic [DATA_W-1:0] b_sl;
    logic [DATA_W-1:0] ab_src;
    logic [DATA_W-1:0] ba_src;

    rbt_log_type       log_in;
    logic              log_push;
    logic              log_room;
    rbt_log_type       log_head;
    logic              log_valid;
    logic              log_pop;
    logic [LOG_CNT_W-1:0] log_cnt;

    // Outputs straight from flops
    assign pready    = s_r.pready;
    assign prdata    = s_r.prdata;
    assign pslverr   = s_r.pslverr;
    assign a_out     = s_r.a_out;
    assign a_oe      = s_r.a_oe;
    assign b_out     = s_r.b_out;
    assign b_oe      = s_r.b_oe;
    assign log_ready = s_r.log_ready;

    // Edges seen on the second sync stage against its delayed copy
    assign ab_edge = s_r.cab[1] && !s_r.cab_d;
    assign ba_edge = s_r.cba[1] && !s_r.cba_d;

    // Real-time drive configurations
    assign ab_rt     = s_r.ctl.ab_en && !s_r.ctl.a_to_b_source_select;
    assign ba_rt     = !s_r.ctl.ba_en_n && !s_r.ctl.b_to_a_source_select;
    assign hold_mode = ab_rt && ba_rt;

    // A port driven live from B makes B the true value on both buses
    assign ab_src = (ba_rt && !ab_rt) ? s_r.b_s : s_r.a_s;
    assign ba_src = ab_rt ? s_r.a_s : s_r.b_s;

    // Per-bit output multiplexer, every slice shares the same controls
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_slice
            assign b_sl[gi] = hold_mode ? s_r.hold[gi] :
                              (s_r.ctl.a_to_b_source_select ? d_r.ab[gi] : s_r.a_s[gi]);
            assign a_sl[gi] = hold_mode ? s_r.hold[gi] :
                              (s_r.ctl.b_to_a_source_select ? d_r.ba[gi] : s_r.b_s[gi]);
        end
    endgenerate

    // Log entry for every capture edge
    assign log_in.ba_hit = ba_edge;
    assign log_in.ab_hit = ab_edge;
    assign log_in.b      = ba_src;
    assign log_in.a      = ab_src;
    assign log_push      = ab_edge || ba_edge;

    // Head word leaves only at the completing edge of a log read
    assign log_pop = (s_r.ph == APB_ACK) && psel && !pwrite &&
                     (paddr == LOG_OFS);

    rbt_fifo #(
        .W     (LOG_W),
        .DEPTH (LOG_DEPTH)
    ) u_log (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (log_push),
        .in_ready  (log_room),
        .in_data   (log_in),
        .out_valid (log_valid),
        .out_ready (log_pop),
        .out_data  (log_head),
        .count     (log_cnt)
    );

    // Address decode and read word
    always_comb begin
        addr_hit = 1'b1;
        rd_word  = '0;
        case (paddr)
            CTRL_OFS: begin
                rd_word[CTRL_W-1:0] = s_r.ctl;
            end
            STORE_OFS: begin
                rd_word[DATA_W-1:0]         = d_r.ab;
                rd_word[HI_LSB +: DATA_W]   = d_r.ba;
            end
            LIVE_OFS: begin
                rd_word[DATA_W-1:0]         = s_r.a_s;
                rd_word[HI_LSB +: DATA_W]   = s_r.b_s;
            end
            LOG_OFS: begin
                rd_word[LOG_W-1:0]          = log_valid ? log_head : '0;
                rd_word[LOG_VALID_BIT]      = log_valid;
            end
            STAT_OFS: begin
                rd_word[STAT_OVF_BIT]              = s_r.ovf;
                rd_word[STAT_CNT_LSB +: LOG_CNT_W] = log_cnt;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    // Next state of the whole block
    always_comb begin
        s_nxt = s_r;

        // Two-stage synchronisers on every bus and capture pin; APB inputs are not synchronised
        s_nxt.a_m   = a_in;
        s_nxt.a_s   = s_r.a_m;
        s_nxt.b_m   = b_in;
        s_nxt.b_s   = s_r.b_m;
        s_nxt.cab   = {s_r.cab[0], a_side_capture_clock};
        s_nxt.cba   = {s_r.cba[0], b_side_capture_clock};
        s_nxt.cab_d = s_r.cab[1];
        s_nxt.cba_d = s_r.cba[1];

        // Latch keeps whatever the A bus shows, so the loop reinforces it
        s_nxt.hold = s_r.a_s;

        // Registered mux outputs cannot glitch between live and stored
        s_nxt.a_out = a_sl;
        s_nxt.b_out = b_sl;
        s_nxt.a_oe  = !s_r.ctl.ba_en_n;
        s_nxt.b_oe  = s_r.ctl.ab_en;

        // Full queue drops the entry but capture itself still happens
        s_nxt.log_ready = log_room;
        if (log_push && !log_room) begin
            s_nxt.ovf = 1'b1;
        end

        // APB: one wait state, write committed at the completing edge
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        case (s_r.ph)
            APB_IDLE: begin
                if (psel && penable) begin
                    s_nxt.ph      = APB_ACK;
                    s_nxt.pready  = 1'b1;
                    s_nxt.pslverr = !addr_hit;
                    s_nxt.prdata  = pwrite ? '0 : rd_word;
                end
            end
            APB_ACK: begin
                s_nxt.ph = APB_IDLE;
                if (psel && pwrite && paddr == CTRL_OFS) begin
                    s_nxt.ctl = rbt_ctrl_type'(pwdata[CTRL_W-1:0]);
                end
                // Overflow clears on a written one, a new drop wins
                if (psel && pwrite && paddr == STAT_OFS &&
                    pwdata[STAT_OVF_BIT] && !(log_push && !log_room)) begin
                    s_nxt.ovf = 1'b0;
                end
            end
            default: begin
                s_nxt.ph = APB_IDLE;
            end
        endcase
    end

    // Capture registers load on their own edge, whatever drives the port
    always_comb begin
        d_nxt = d_r;
        if (ab_edge) begin
            d_nxt.ab = ab_src;
        end
        // Same-cycle edges under a stored select are left to outside timing
        if (ba_edge) begin
            d_nxt.ba = ba_src;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r     <= '0;
            s_r.ctl <= CTRL_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // No reset: power-up contents are whatever the flops wake with
    always_ff @(posedge pclk) begin
        d_r <= d_nxt;
    end

    // Checks on the data path

    a_cap_ab_load: assert property (@(posedge pclk) disable iff (!presetn)
        ab_edge && !(ba_rt && !ab_rt) |=> d_r.ab == $past(s_r.a_s))
        else $error("A-to-B register missed its capture");

    a_cap_ba_load: assert property (@(posedge pclk) disable iff (!presetn)
        ba_edge && !ab_rt |=> d_r.ba == $past(s_r.b_s))
        else $error("B-to-A register missed its capture");

    a_rt_ab_both: assert property (@(posedge pclk) disable iff (!presetn)
        ab_rt && ba_edge |=> d_r.ba == $past(s_r.a_s))
        else $error("B-to-A register did not take live A");

    a_rt_ba_both: assert property (@(posedge pclk) disable iff (!presetn)
        ba_rt && !ab_rt && ab_edge |=> d_r.ab == $past(s_r.b_s))
        else $error("A-to-B register did not take live B");

    a_isolation_off: assert property (@(posedge pclk) disable iff (!presetn)
        !s_r.ctl.ab_en && s_r.ctl.ba_en_n |=> !a_oe && !b_oe)
        else $error("Port driven during isolation");

    a_live_b_path: assert property (@(posedge pclk) disable iff (!presetn)
        ab_rt && !hold_mode |=> b_oe && b_out == $past(s_r.a_s))
        else $error("B port not following live A");

    a_stored_b_path: assert property (@(posedge pclk) disable iff (!presetn)
        s_r.ctl.ab_en && s_r.ctl.a_to_b_source_select |=> b_oe && b_out == $past(d_r.ab))
        else $error("B port not showing stored A data");

    a_live_a_path: assert property (@(posedge pclk) disable iff (!presetn)
        ba_rt && !hold_mode |=> a_oe && a_out == $past(s_r.b_s))
        else $error("A port not following live B");

    a_stored_a_path: assert property (@(posedge pclk) disable iff (!presetn)
        !s_r.ctl.ba_en_n && s_r.ctl.b_to_a_source_select |=> a_oe && a_out == $past(d_r.ba))
        else $error("A port not showing stored B data");

    a_dual_stored: assert property (@(posedge pclk) disable iff (!presetn)
        s_r.ctl == 4'hD ##1 s_r.ctl == 4'hD |=>
        a_oe && b_oe && a_out == $past(d_r.ba) && b_out == $past(d_r.ab))
        else $error("Dual stored drive broken");

    a_hold_loop: assert property (@(posedge pclk) disable iff (!presetn)
        hold_mode |=> a_oe && b_oe && a_out == b_out && a_out == $past(s_r.hold))
        else $error("Bus hold loop not reinforcing");

    // Mux, enable and storage checks; stored-source checks need one capture since power-up

    a_sel_live_b: assert property (@(posedge pclk) disable iff (!presetn)
        !hold_mode && !s_r.ctl.a_to_b_source_select |=> b_out == $past(s_r.a_s))
        else $error("B drive not taken from live A");

    a_sel_live_a: assert property (@(posedge pclk) disable iff (!presetn)
        !hold_mode && !s_r.ctl.b_to_a_source_select |=> a_out == $past(s_r.b_s))
        else $error("A drive not taken from live B");

    a_sel_stored_b: assert property (@(posedge pclk) disable iff (!presetn)
        !hold_mode && s_r.ctl.a_to_b_source_select |=> b_out == $past(d_r.ab))
        else $error("B drive not taken from stored A");

    a_sel_stored_a: assert property (@(posedge pclk) disable iff (!presetn)
        !hold_mode && s_r.ctl.b_to_a_source_select |=> a_out == $past(d_r.ba))
        else $error("A drive not taken from stored B");

    a_glitch_b: assert property (@(posedge pclk) disable iff (!presetn)
        !hold_mode && d_r.ab == s_r.a_s |=> b_out == $past(s_r.a_s))
        else $error("B drive moved although both sources agree");

    a_glitch_a: assert property (@(posedge pclk) disable iff (!presetn)
        !hold_mode && d_r.ba == s_r.b_s |=> a_out == $past(s_r.b_s))
        else $error("A drive moved although both sources agree");

    a_drive_enables: assert property (@(posedge pclk) disable iff (!presetn)
        1'b1 |=> a_oe == !$past(s_r.ctl.ba_en_n) && b_oe == $past(s_r.ctl.ab_en))
        else $error("Drive enables do not follow control");

    a_ab_keep: assert property (@(posedge pclk) disable iff (!presetn)
        ab_edge ##1 !ab_edge |=> d_r.ab == $past(d_r.ab))
        else $error("A-to-B register changed without its edge");

    a_ba_keep: assert property (@(posedge pclk) disable iff (!presetn)
        ba_edge ##1 !ba_edge |=> d_r.ba == $past(d_r.ba))
        else $error("B-to-A register changed without its edge");

    a_log_overflow: assert property (@(posedge pclk) disable iff (!presetn)
        log_push && !log_room |=> s_r.ovf)
        else $error("Dropped capture entry not flagged");

endmodule // rbt_top

/* File: verif/rbt_bus_model.sv */
// Far-side logic on the two buses, resolving each line from every driver
module rbt_bus_model
    import rbt_pkg::*;
(
    input  wire logic              pclk,     // Clock
    input  wire logic [DATA_W-1:0] a_out,    // Device drive on A
    input  wire logic              a_oe,     // Device drives A
    input  wire logic [DATA_W-1:0] b_out,    // Device drive on B
    input  wire logic              b_oe,     // Device drives B
    input  wire logic [DATA_W-1:0] a_drv,    // Far-side value for A
    input  wire logic              a_drv_en, // Far side drives A
    input  wire logic [DATA_W-1:0] b_drv,    // Far-side value for B
    input  wire logic              b_drv_en, // Far side drives B
    output      logic [DATA_W-1:0] a_in,     // Resolved A level
    output      logic [DATA_W-1:0] b_in      // Resolved B level
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [DATA_W-1:0] a_last_r;
    logic [DATA_W-1:0] b_last_r;

    // Remember levels so a floating line never passes for a held value
    always_ff @(posedge pclk) begin
        a_last_r <= a_in;
        b_last_r <= b_in;
    end

    // Device drive wins; a released line with no keeper toggles every cycle
    assign a_in = a_oe ? a_out : (a_drv_en ? a_drv : ~a_last_r);
    assign b_in = b_oe ? b_out : (b_drv_en ? b_drv : ~b_last_r);
endmodule // rbt_bus_model

/* File: verif/testbench.sv */
// Self-checking bench: APB control plus capture pulses on the two buses
module testbench
    import rbt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              pclk     = 1'b0;
    logic              presetn  = 1'b0;
    logic              psel     = 1'b0;
    logic              penable  = 1'b0;
    logic              pwrite   = 1'b0;
    logic [ADDR_W-1:0] paddr    = 12'h000;
    logic [31:0]       pwdata   = 32'h0;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
    logic              a_clk    = 1'b0;
    logic              b_clk    = 1'b0;
    logic [DATA_W-1:0] a_in;
    logic [DATA_W-1:0] a_out;
    logic              a_oe;
    logic [DATA_W-1:0] b_in;
    logic [DATA_W-1:0] b_out;
    logic              b_oe;
    logic              log_ready;
    logic [DATA_W-1:0] a_drv    = 8'h5A;
    logic [DATA_W-1:0] b_drv    = 8'hC3;
    logic              a_drv_en = 1'b1;
    logic              b_drv_en = 1'b1;
    logic [31:0]       rd;
    logic              err;
    int                errors   = 0;
    int                checks   = 0;
    int                cycles   = 0;

    // 25 MHz clock
    always #20 pclk = ~pclk;

    rbt_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .a_side_capture_clock(a_clk), .b_side_capture_clock(b_clk),
        .a_in(a_in), .a_out(a_out), .a_oe(a_oe), .b_in(b_in), .b_out(b_out),
        .b_oe(b_oe), .log_ready(log_ready)
    );

    rbt_bus_model far (
        .pclk(pclk), .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
        .a_drv(a_drv), .a_drv_en(a_drv_en), .b_drv(b_drv), .b_drv_en(b_drv_en),
        .a_in(a_in), .b_in(b_in)
    );

    task automatic report_and_stop();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Cut a hang short; the whole run needs a few hundred cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] addr,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Capture pulse, high held three cycles then low seven, for the pin synchroniser
    task automatic pulse(input logic a, input logic b);
        @(posedge pclk);
        a_clk <= a;
        b_clk <= b;
        cyc(3);
        a_clk <= 1'b0;
        b_clk <= 1'b0;
        cyc(7);
    endtask

    initial begin
        cyc(3);
        presetn <= 1'b1;
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h0000_0002);
        chk({a_oe, b_oe}, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        chk(err, 32'h1);
        chk(rd, 32'h0);
        // Isolation: both ports only listen, simultaneous capture allowed
        pulse(1'b1, 1'b1);
        apb(1'b0, STORE_OFS, 32'h0);
        chk(rd, 32'h0000_C35A);
        apb(1'b0, LIVE_OFS, 32'h0);
        chk(rd, 32'h0000_C35A);
        // Live A onto B, then both captures see the A value
        apb(1'b1, CTRL_OFS, 32'h3);
        b_drv_en <= 1'b0;
        a_drv    <= 8'h3C;
        cyc(6);
        chk({a_oe, b_oe}, 32'h1);
        chk(b_out, 32'h3C);
        pulse(1'b1, 1'b1);
        apb(1'b0, STORE_OFS, 32'h0);
        chk(rd, 32'h0000_3C3C);
        // Live to stored with equal values: B must not move at any cycle
        fork
            apb(1'b1, CTRL_OFS, 32'h7);
            repeat (8) begin
                @(posedge pclk);
                chk(b_out, 32'h3C);
            end
        join
        a_drv <= 8'h99;
        cyc(6);
        chk(b_out, 32'h3C);
        pulse(1'b1, 1'b0);
        chk(b_out, 32'h99);
        apb(1'b0, STORE_OFS, 32'h0);
        chk(rd, 32'h0000_3C99);
        // Live B onto A
        apb(1'b1, CTRL_OFS, 32'h0);
        a_drv_en <= 1'b0;
        b_drv_en <= 1'b1;
        b_drv    <= 8'h66;
        cyc(6);
        chk({a_oe, b_oe, a_out}, {1'b1, 1'b0, 8'h66});
        pulse(1'b1, 1'b1);
        apb(1'b0, STORE_OFS, 32'h0);
        chk(rd, 32'h0000_6666);
        // Stored B onto A; the other register keeps its contents
        apb(1'b1, CTRL_OFS, 32'h8);
        b_drv <= 8'h11;
        cyc(6);
        chk(a_out, 32'h66);
        pulse(1'b0, 1'b1);
        chk(a_out, 32'h11);
        apb(1'b0, STORE_OFS, 32'h0);
        chk(rd, 32'h0000_1166);
        // Both ports driven from storage
        apb(1'b1, CTRL_OFS, 32'hD);
        b_drv_en <= 1'b0;
        cyc(6);
        chk({a_oe, b_oe, a_out, b_out}, {2'b11, 8'h11, 8'h66});
        // Both live and enabled: the buses keep their last state unaided
        apb(1'b1, CTRL_OFS, 32'h2);
        a_drv_en <= 1'b1;
        b_drv_en <= 1'b1;
        a_drv    <= 8'hA5;
        cyc(6);
        apb(1'b1, CTRL_OFS, 32'h1);
        cyc(2);
        a_drv_en <= 1'b0;
        b_drv_en <= 1'b0;
        cyc(10);
        chk({a_oe, b_oe, a_out, b_out}, {2'b11, 8'hA5, 8'hA5});
        // Capture log: empty it, overfill by one, then drain in order
        apb(1'b1, CTRL_OFS, 32'h2);
        a_drv_en <= 1'b1;
        b_drv_en <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            apb(1'b0, LOG_OFS, 32'h0);
            if (rd[LOG_VALID_BIT] !== 1'b1) break;
        end
        apb(1'b1, STAT_OFS, 32'h1);
        for (int k = 0; k < 9; k++) begin
            a_drv <= 8'(k + 32'h10);
            cyc(4);
            pulse(1'b1, 1'b0);
        end
        chk(log_ready, 32'h0);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd, 32'h0000_0801);
        for (int k = 0; k < 8; k++) begin
            apb(1'b0, LOG_OFS, 32'h0);
            chk({rd[31], rd[17:16], rd[7:0]}, {1'b1, 2'b01, 8'(k + 32'h10)});
        end
        apb(1'b0, LOG_OFS, 32'h0);
        chk(rd[31], 32'h0);
        cyc(2);
        chk(log_ready, 32'h1);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd, 32'h0000_0001);
        apb(1'b1, STAT_OFS, 32'h1);
        apb(1'b0, STAT_OFS, 32'h0);
        chk(rd, 32'h0);
        report_and_stop();
    end
endmodule // testbench
